// ===== hw/stb_pkg.sv
/*
 Constants for the triplet and block-receive command engine.
 Assumes a 100 MHz mclk and one slot generator on the line.
*/
package stb_pkg;
   localparam int CLK_MHZ = 100;
   localparam logic [7:0] CMD_TRIPLET = 8'h78;
   localparam logic [7:0] CMD_BLOCK_RX = 8'hE1;
   localparam int DIR_BIT = 7;
   localparam int BS_MSB = 5;
   localparam int BS_W = 6;
   localparam logic [5:0] SP_BASE = 6'h00;
   localparam logic [5:0] BS_ZERO = 6'h00;
   localparam logic [5:0] BS_ONE = 6'h01;
   localparam logic [1:0] TRIP_READS = 2'h2;
   localparam logic [2:0] BITS_LAST = 3'h7;
   localparam int START_MAX_NS = 1090;
   localparam int START_MAX_CYC = START_MAX_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 16;
   typedef enum logic [2:0] {
      STB_IDLE, STB_PARAM_TRIP, STB_PARAM_BLK, STB_TRIP, STB_BLK
   } stb_state_type;
endpackage

// ===== hw/stb_slot.sv
/*
 One line time slot: low phase, sample instant, recovery.
 Assumes line_in is already synchronised to mclk.
*/
`timescale 1ns/1ns
module stb_slot (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic wbit,
   input wire logic [stb_pkg::CNT_W-1:0] period,
   input wire logic [stb_pkg::CNT_W-1:0] low_one,
   input wire logic [stb_pkg::CNT_W-1:0] low_zero,
   input wire logic [stb_pkg::CNT_W-1:0] sample_at,
   input wire logic line_in,
   output logic drive_low,
   output logic active,
   output logic sample_pulse,
   output logic sample_bit,
   output logic done
);
   import stb_pkg::*;
   logic [CNT_W-1:0] cnt_r;
   logic active_r;
   logic wbit_r;
   logic [CNT_W-1:0] low_len;

   // Slot counter, restarted back to back
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= '0;
         active_r <= 1'b0;
         wbit_r <= 1'b1;
      end else if (start) begin
         cnt_r <= '0;
         active_r <= 1'b1;
         wbit_r <= wbit;
      end else if (active_r) begin
         if (cnt_r == period - 1'b1) begin
            active_r <= 1'b0;
         end
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Sampled line level at the sample instant
   always_ff @(posedge mclk) begin
      if (rst) begin
         sample_bit <= 1'b0;
      end else if (sample_pulse) begin
         sample_bit <= line_in;
      end
   end

   always_comb begin
      low_len = wbit_r ? low_one : low_zero;
      drive_low = active_r && (cnt_r < low_len);
      sample_pulse = active_r && (cnt_r == sample_at);
      done = active_r && (cnt_r == period - 1'b1);
      active = active_r;
   end
endmodule

// ===== hw/stb_cmd.sv
/*
 Command engine for the search triplet and the block receive.
 Assumes the I2C slave logic presents decoded command and
 parameter bytes as one-cycle pulses on mclk, and owns the
 read pointer and scratchpad storage.
*/
`timescale 1ns/1ns
module stb_cmd #(
   parameter int SLOT_STD = 7000,
   parameter int SLOT_OD = 1000,
   parameter int LOW1_STD = 600,
   parameter int LOW1_OD = 100,
   parameter int LOW0_STD = 6000,
   parameter int LOW0_OD = 750,
   parameter int SAMP_STD = 1000,
   parameter int SAMP_OD = 150
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic cmd_ack,
   input wire logic param_valid,
   input wire logic [7:0] param_byte,
   input wire logic overdrive_speed_select,
   input wire logic active_pullup_select,
   output logic line_busy_flag,
   output logic single_bit_result,
   output logic triplet_second_bit,
   output logic branch_dir,
   output logic rdptr_to_status,
   output logic sp_we,
   output logic [stb_pkg::BS_W-1:0] sp_addr,
   output logic [7:0] sp_wdata,
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_n,
   output logic line_pullup_en
);
   import stb_pkg::*;
   stb_state_type state_r;
   logic line_s1_r;
   logic line_s2_r;
   logic dir_v_r;
   logic [1:0] slot_idx_r;
   logic [2:0] bit_idx_r;
   logic [BS_W-1:0] byte_idx_r;
   logic [BS_W-1:0] last_byte_r;
   logic [7:0] shift_r;
   logic slot_start;
   logic slot_wbit;
   logic drive_low;
   logic slot_active;
   logic sample_pulse;
   logic sample_bit;
   logic slot_done;
   logic known_code;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] low_one;
   logic [CNT_W-1:0] low_zero;
   logic [CNT_W-1:0] sample_at;
   logic [BS_W-1:0] bs_field;
   logic [7:0] rx_byte;

   // Line input synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         line_s1_r <= 1'b1;
         line_s2_r <= 1'b1;
      end else begin
         line_s1_r <= line_i;
         line_s2_r <= line_s1_r;
      end
   end

   always_comb begin
      period = overdrive_speed_select ? CNT_W'(SLOT_OD) : CNT_W'(SLOT_STD);
      low_one = overdrive_speed_select ? CNT_W'(LOW1_OD) : CNT_W'(LOW1_STD);
      low_zero = overdrive_speed_select ? CNT_W'(LOW0_OD) : CNT_W'(LOW0_STD);
      sample_at = overdrive_speed_select ? CNT_W'(SAMP_OD) : CNT_W'(SAMP_STD);
      known_code = (cmd_code == CMD_TRIPLET) || (cmd_code == CMD_BLOCK_RX);
      // Answer depends on the code and busy, never stalls the bus
      cmd_ack = cmd_valid && known_code && !line_busy_flag;
      rdptr_to_status = cmd_ack;
      bs_field = param_byte[BS_MSB:0];
      rx_byte = {sample_bit, shift_r[7:1]};
   end

   // Command sequencing; the first slot starts on the parameter byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= STB_IDLE;
      end else begin
         case (state_r)
            STB_IDLE, STB_PARAM_TRIP, STB_PARAM_BLK: begin
               if (cmd_ack) begin
                  state_r <= (cmd_code == CMD_TRIPLET) ?
                     STB_PARAM_TRIP : STB_PARAM_BLK;
               end else if (param_valid && state_r == STB_PARAM_TRIP) begin
                  state_r <= STB_TRIP;
               end else if (param_valid && state_r == STB_PARAM_BLK) begin
                  state_r <= STB_BLK;
               end else if (cmd_valid) begin
                  state_r <= STB_IDLE;
               end
            end
            STB_TRIP: begin
               if (slot_done && slot_idx_r == TRIP_READS) begin
                  state_r <= STB_IDLE;
               end
            end
            STB_BLK: begin
               if (slot_done && bit_idx_r == BITS_LAST &&
                   byte_idx_r == last_byte_r) begin
                  state_r <= STB_IDLE;
               end
            end
            default: state_r <= STB_IDLE;
         endcase
      end
   end

   // Busy flag: set at parameter, cleared with the last slot
   always_ff @(posedge mclk) begin
      if (rst) begin
         line_busy_flag <= 1'b0;
      end else if (param_valid && (state_r == STB_PARAM_TRIP ||
                                   state_r == STB_PARAM_BLK)) begin
         line_busy_flag <= 1'b1;
      end else if (slot_done && ((state_r == STB_TRIP &&
                  slot_idx_r == TRIP_READS) || (state_r == STB_BLK &&
                  bit_idx_r == BITS_LAST && byte_idx_r == last_byte_r))) begin
         line_busy_flag <= 1'b0;
      end
   end

   // Parameter capture and slot counters
   always_ff @(posedge mclk) begin
      if (rst) begin
         dir_v_r <= 1'b0;
         last_byte_r <= BS_ZERO;
         slot_idx_r <= 2'h0;
         bit_idx_r <= 3'h0;
         byte_idx_r <= SP_BASE;
      end else if (param_valid && (state_r == STB_PARAM_TRIP ||
                                   state_r == STB_PARAM_BLK)) begin
         dir_v_r <= param_byte[DIR_BIT];
         // Zero length reads one byte
         last_byte_r <= (bs_field == BS_ZERO) ? BS_ZERO : bs_field - BS_ONE;
         slot_idx_r <= 2'h0;
         bit_idx_r <= 3'h0;
         byte_idx_r <= SP_BASE;
      end else if (slot_done) begin
         slot_idx_r <= slot_idx_r + 2'h1;
         bit_idx_r <= bit_idx_r + 3'h1;
         if (bit_idx_r == BITS_LAST) begin
            byte_idx_r <= byte_idx_r + BS_ONE;
         end
      end
   end

   // Triplet result bits
   always_ff @(posedge mclk) begin
      if (rst) begin
         single_bit_result <= 1'b0;
         triplet_second_bit <= 1'b0;
         branch_dir <= 1'b0;
      end else if (state_r == STB_TRIP && sample_pulse) begin
         if (slot_idx_r == 2'h0) begin
            single_bit_result <= line_s2_r;
         end else if (slot_idx_r == 2'h1) begin
            triplet_second_bit <= line_s2_r;
            // Path choice
            if (single_bit_result != line_s2_r) begin
               branch_dir <= single_bit_result;
            end else if (single_bit_result) begin
               branch_dir <= 1'b1;
            end else begin
               branch_dir <= dir_v_r;
            end
         end
      end
   end

   // Byte assembly and scratchpad write
   always_ff @(posedge mclk) begin
      if (rst) begin
         shift_r <= 8'h00;
         sp_we <= 1'b0;
         sp_addr <= SP_BASE;
         sp_wdata <= 8'h00;
      end else begin
         sp_we <= 1'b0;
         if (state_r == STB_BLK && slot_done) begin
            shift_r <= rx_byte;
            if (bit_idx_r == BITS_LAST) begin
               sp_we <= 1'b1;
               sp_addr <= byte_idx_r;
               sp_wdata <= rx_byte;
            end
         end
      end
   end

   always_comb begin
      slot_start = 1'b0;
      slot_wbit = 1'b1;
      if (param_valid && (state_r == STB_PARAM_TRIP ||
                          state_r == STB_PARAM_BLK)) begin
         slot_start = 1'b1;
      end else if (slot_done && state_r == STB_TRIP &&
                   slot_idx_r != TRIP_READS) begin
         slot_start = 1'b1;
         slot_wbit = (slot_idx_r == 2'h1) ? branch_next() : 1'b1;
      end else if (slot_done && state_r == STB_BLK &&
                   !(bit_idx_r == BITS_LAST &&
                     byte_idx_r == last_byte_r)) begin
         slot_start = 1'b1;
      end
   end

   // Write bit for the third triplet slot, from the fresh results
   function automatic logic branch_next();
      return branch_dir;
   endfunction

   stb_slot u_slot (
      .mclk(mclk),
      .rst(rst),
      .start(slot_start),
      .wbit(slot_wbit),
      .period(period),
      .low_one(low_one),
      .low_zero(low_zero),
      .sample_at(sample_at),
      .line_in(line_s2_r),
      .drive_low(drive_low),
      .active(slot_active),
      .sample_pulse(sample_pulse),
      .sample_bit(sample_bit),
      .done(slot_done)
   );

   always_comb begin
      line_o = 1'b0;
      line_oe_n = !drive_low;
      line_pullup_en = active_pullup_select && slot_active && !drive_low;
   end
endmodule

// ===== sim/stb_cmd_props.sv
/*
 Checker for the triplet and block-receive command engine.
 Sees only stb_cmd ports; bound below with its slot parameters.
*/
`timescale 1ns/1ns
module stb_cmd_chk
   import stb_pkg::*;
#(
   parameter int SLOT_STD = 7000,
   parameter int SLOT_OD = 1000
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_ack,
   input wire logic param_valid,
   input wire logic [7:0] param_byte,
   input wire logic overdrive_speed_select,
   input wire logic active_pullup_select,
   input wire logic line_busy_flag,
   input wire logic rdptr_to_status,
   input wire logic sp_we,
   input wire logic [stb_pkg::BS_W-1:0] sp_addr,
   input wire logic line_pullup_en,
   input wire logic line_oe_n
);
   logic pend_r, trip_r;
   logic [6:0] n_r;
   int bcnt_r, p, lim;
   assign p = overdrive_speed_select ? SLOT_OD : SLOT_STD;
   assign lim = trip_r ? 3 * p : 8 * int'(n_r) * p;
   // Pending command, kind, length and busy length
   always_ff @(posedge mclk) begin
      if (rst) begin
         pend_r <= 1'b0;
         trip_r <= 1'b0;
         n_r <= 7'h01;
         bcnt_r <= 0;
      end else begin
         if (cmd_valid) pend_r <= cmd_ack;
         else if (param_valid) pend_r <= 1'b0;
         if (cmd_ack) trip_r <= (cmd_code == CMD_TRIPLET);
         if (param_valid && pend_r)
            n_r <= (param_byte[5:0] == 6'h00) ? 7'h01 :
               {1'b0, param_byte[5:0]};
         bcnt_r <= line_busy_flag ? bcnt_r + 1 : 0;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   busy_refusal_a: assert property (
      cmd_valid && line_busy_flag |-> !cmd_ack)
      else $error("code acknowledged while busy");
   code_ack_a: assert property (cmd_valid && !line_busy_flag |-> cmd_ack ==
      (cmd_code == CMD_TRIPLET || cmd_code == CMD_BLOCK_RX))
      else $error("wrong acknowledge for code");
   read_ptr_a: assert property (rdptr_to_status == cmd_ack)
      else $error("read pointer move differs from acknowledge");
   slot_start_a: assert property (param_valid && pend_r |=>
      line_busy_flag && !line_oe_n)
      else $error("line activity late");
   busy_len_a: assert property (
      $fell(line_busy_flag) |-> bcnt_r == lim)
      else $error("busy length wrong");
   busy_bound_a: assert property (line_busy_flag |-> bcnt_r < lim)
      else $error("busy overran");
   sp_addr_a: assert property (sp_we |-> {1'b0, sp_addr} < n_r)
      else $error("scratchpad address beyond length");
   trip_nowr_a: assert property (sp_we |-> !trip_r)
      else $error("scratchpad written by triplet");
   idle_release_a: assert property (!line_busy_flag |-> line_oe_n)
      else $error("line driven while idle");
   pullup_gate_a: assert property (
      line_pullup_en == (active_pullup_select && line_busy_flag && line_oe_n))
      else $error("active pullup outside released slot phase");
   cover property ($fell(line_busy_flag) && trip_r);
   cover property ($fell(line_busy_flag) && !trip_r);
   cover property (cmd_valid && line_busy_flag);
   cover property (line_pullup_en);
endmodule
bind stb_cmd stb_cmd_chk #(.SLOT_STD(SLOT_STD), .SLOT_OD(SLOT_OD)) chk_inst (
   .mclk, .rst, .cmd_valid, .cmd_code, .cmd_ack, .param_valid, .param_byte,
   .overdrive_speed_select, .active_pullup_select, .line_busy_flag,
   .rdptr_to_status, .sp_we, .sp_addr, .line_pullup_en, .line_oe_n);

// ===== sim/stb_slave.sv
/*
 Line slave model: answers each slot from a bit pattern.
 Assumes the line is pulled up and sampled on mclk.
*/
`timescale 1ns/1ns
module stb_slave (
   input wire logic mclk,
   input wire logic restart,
   input wire logic [63:0] pattern,
   input wire logic line,
   output logic pull_low
);
   logic line_d;
   logic [5:0] idx;
   int hold;
   // Stretch low phase for a zero bit
   always @(posedge mclk) begin
      line_d <= line;
      if (restart) begin
         idx <= 6'h00;
         hold <= 0;
      end else if (line_d && !line) begin
         if (!pattern[idx]) hold <= 12;
         idx <= idx + 6'h01;
      end else if (hold > 0) hold <= hold - 1;
   end
   assign pull_low = hold > 0;
endmodule

// ===== sim/tb.sv
/*
 Testbench for stb_cmd: triplets, refusals and block receives.
 Assumes stb_slave on the line with a pullup.
*/
`timescale 1ns/1ns
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
   import stb_pkg::*;
   logic mclk = 0, rst = 1, cmd_valid = 0, param_valid = 0, restart = 1;
   logic overdrive_speed_select = 0, active_pullup_select = 1;
   logic [7:0] cmd_code = 8'h00, param_byte = 8'h00, sp_wdata;
   logic [63:0] pattern = 64'h0123456789ABCDEF;
   logic cmd_ack, line_busy_flag, single_bit_result, triplet_second_bit;
   logic branch_dir, rdptr_to_status, sp_we, line_o, line_oe_n;
   logic line_pullup_en, pull_low;
   logic [5:0] sp_addr;
   logic [7:0] got [64];
   logic [3:0] tv [5] = '{4'hC, 4'h3, 4'h7, 4'h0, 4'h9};
   int nwr = 0, error_cnt = 0, tests_run = 0, cyc = 0;
   int low_run = 0, last_low = 0, exp_low = 0;
   localparam int SL_STD = 40, SL_OD = 20, SM_STD = 10, SM_OD = 6;
   localparam int L1_STD = 4, L1_OD = 2, L0_STD = 30, L0_OD = 15;
   wire line_i = line_oe_n & ~pull_low;
   stb_cmd #(.SLOT_STD(SL_STD), .SLOT_OD(SL_OD), .LOW1_STD(L1_STD),
      .LOW1_OD(L1_OD), .LOW0_STD(L0_STD), .LOW0_OD(L0_OD),
      .SAMP_STD(SM_STD), .SAMP_OD(SM_OD)) stb_cmd_inst (
      .mclk, .rst, .cmd_valid, .cmd_code, .cmd_ack, .param_valid,
      .param_byte, .overdrive_speed_select, .active_pullup_select,
      .line_busy_flag, .single_bit_result, .triplet_second_bit, .branch_dir,
      .rdptr_to_status, .sp_we, .sp_addr, .sp_wdata, .line_i, .line_o,
      .line_oe_n, .line_pullup_en);
   stb_slave stb_slave_inst (.mclk, .restart, .pattern, .line(line_i),
      .pull_low);
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (sp_we === 1'b1) begin
         got[sp_addr] = sp_wdata;
         nwr++;
      end
      // Length of the latest low phase driven by the block
      if (line_oe_n === 1'b0) low_run++;
      else if (low_run != 0) begin
         last_low = low_run;
         low_run = 0;
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize;
      end
   end
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task cmd(input logic [7:0] c, input logic ea);
      cmd_valid = 1;
      cmd_code = c;
      #1 `CHK(cmd_ack, ea)
      `CHK(rdptr_to_status, ea)
      @(posedge mclk) #1 cmd_valid = 0;
   endtask
   task param(input logic [7:0] p);
      param_valid = 1;
      param_byte = p;
      @(posedge mclk) #1 param_valid = 0;
   endtask
   task wait_idle;
      while (line_busy_flag !== 1'b0) begin
         @(posedge mclk);
         #1;
      end
      #1 restart = 1;
      @(posedge mclk) #1 restart = 0;
   endtask
   task blk(input logic [7:0] p, input int n);
      nwr = 0;
      got = '{default: 8'hXX};
      cmd(CMD_BLOCK_RX, 1);
      param(p);
      wait_idle;
      `CHK(nwr, n)
      for (int k = 0; k < n; k++) `CHK(got[k], pattern[8*(k%8)+:8])
      $display("test block of %0d bytes done", n);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      #1 rst = 0;
      restart = 0;
      for (int i = 0; i < 5; i++) begin
         overdrive_speed_select = i[0];
         active_pullup_select = i[1];
         pattern = {61'h0, 1'b1, tv[i][2], tv[i][1]};
         cmd(CMD_TRIPLET, 1);
         param({tv[i][3], 7'h55});
         cmd(CMD_BLOCK_RX, 0);
         wait_idle;
         `CHK(single_bit_result, tv[i][1])
         `CHK(triplet_second_bit, tv[i][2])
         `CHK(branch_dir, tv[i][0])
         exp_low = i[0] ? (tv[i][0] ? L1_OD : L0_OD) :
            (tv[i][0] ? L1_STD : L0_STD);
         `CHK(last_low, exp_low)
      end
      $display("test triplets done");
      cmd(8'h00, 0);
      param(8'h01);
      repeat (3) @(posedge mclk);
      #1 `CHK(line_busy_flag, 1'b0)
      `CHK(line_o, 1'b0)
      $display("test refusals done");
      pattern = 64'h0123456789ABCDEF;
      active_pullup_select = 1;
      blk(8'hC0, 1);
      overdrive_speed_select = 1;
      blk(8'h3F, 63);
      overdrive_speed_select = 0;
      blk(8'h43, 3);
      summarize;
   end
endmodule
